// *** bench/ssu_codec_model.sv ***
// Behavioural codec driving the receive clock, data and frame pins.
`timescale 1ns/100ps
`default_nettype none
module ssu_codec_model (
  input  wire logic clk,              // Master clock.
  input  wire logic run,              // A frame runs while high.
  output var  logic bitClk = 1'b0,    // Bit clock, still outside frames.
  output var  logic dataOut = 1'b0,   // Serial data.
  output var  logic frameOut = 1'b0   // Frame sync, high during a frame.
);
  logic [2:0]  cntQ = 3'h0;
  logic [15:0] patQ = 16'h5a3c;
  // Idle data flips every cycle so a stale bit never passes for a real one.
  always @(posedge clk) begin
    frameOut <= run;
    if (!run) begin
      bitClk  <= 1'b0;
      cntQ    <= 3'h0;
      dataOut <= ~dataOut;
    end else begin
      cntQ <= cntQ + 3'h1;
      if (cntQ == 3'h7) begin
        bitClk <= ~bitClk;
        if (bitClk) begin
          dataOut <= patQ[15];
          patQ    <= {patQ[14:0], patQ[15]};
        end
      end
    end
  end
endmodule // ssu_codec_model
`default_nettype wire

// *** bench/ssu_core_asserts.sv ***
// Port-level checker for the serial control core.
`timescale 1ns/100ps
`default_nettype none
`include "ssu_defs.vh"
module ssu_core_asserts (
  input wire logic        clk,       // Master clock.
  input wire logic        rst,       // Synchronous reset.
  input wire logic [7:0]  regAddr,   // Register address.
  input wire logic [31:0] regWdata,  // Write data.
  input wire logic        regWr,     // Write strobe.
  input wire logic        regRd,     // Read strobe.
  input wire logic [31:0] regRdata,  // Read data.
  input wire logic        irq,       // Interrupt.
  input wire logic        txData,    // Transmit data.
  input wire logic        txFrame,   // Transmit frame sync.
  input wire logic        txClkOut,  // Transmit clock.
  input wire logic        rxDataIn,  // Receive data pin.
  input wire logic        rxFrameIn, // Receive frame pin.
  input wire logic        rxClkIn,   // Receive clock pin.
  input wire logic        rxClkOut,  // Receive clock drive.
  input wire logic        rxClkOe_n  // Receive clock enable.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A write immediately followed by a read of the mask.
  sequence s_wr(logic [7:0] a); regWr && regAddr == a; endsequence
  sequence s_rd(logic [7:0] a); regRd && regAddr == a; endsequence
  property p_rd_idle; !$past(regRd) |-> regRdata == 32'h00000000; endproperty
  property p_mask_set; s_wr(`SSU_OFF_IEN_SET) ##1 s_rd(`SSU_OFF_IMASK)
    |=> (regRdata & $past(regWdata, 2)) == $past(regWdata, 2); endproperty
  property p_mask_clr; s_wr(`SSU_OFF_IEN_CLR) ##1 s_rd(`SSU_OFF_IMASK)
    |=> (regRdata & $past(regWdata, 2)) == 32'h00000000; endproperty
  property p_irq_off; regWr && regAddr == `SSU_OFF_IEN_CLR && regWdata == 32'hffffffff
    |-> ##2 !irq; endproperty
  property p_wo_zero; regRd && (regAddr == `SSU_OFF_CTRL || regAddr == `SSU_OFF_TXHOLD
    || regAddr == 8'h08) |=> regRdata == 32'h00000000; endproperty
  // Soft reset must leave every pin at its reset level; config is zero so it stays there.
  property p_srst; regWr && regAddr == `SSU_OFF_CTRL && regWdata[15]
    |=> (!txData && !txFrame && !txClkOut && !rxClkOut && rxClkOe_n && !irq) [*2];
  endproperty
  property p_cko_on; regWr && regAddr == `SSU_OFF_RXCLK && regWdata[4:2] == `SSU_CKO_CONT
    |-> ##[1:3] !rxClkOe_n; endproperty
  property p_cko_off; regWr && regAddr == `SSU_OFF_RXCLK && regWdata[4:2] == `SSU_CKO_NONE
    |-> ##[1:3] rxClkOe_n; endproperty
  property p_no_sync; txFrame == 1'b0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_mask_set: assert property (p_mask_set) else $error("mask bit not set");
  a_mask_clr: assert property (p_mask_clr) else $error("mask bit not cleared");
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt high");
  a_wo_zero: assert property (p_wo_zero) else $error("write-only read nonzero");
  a_srst: assert property (p_srst) else $error("soft reset left pins active");
  a_cko_on: assert property (p_cko_on) else $error("clock pin not driven");
  a_cko_off: assert property (p_cko_off) else $error("clock pin still driven");
  a_no_sync: assert property (p_no_sync) else $error("sync data sent");
  c_irq: cover property (irq);
endmodule // ssu_core_asserts
bind ssu_core ssu_core_asserts chk_u (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
  .txData(txData), .txFrame(txFrame), .txClkOut(txClkOut), .rxDataIn(rxDataIn),
  .rxFrameIn(rxFrameIn), .rxClkIn(rxClkIn), .rxClkOut(rxClkOut), .rxClkOe_n(rxClkOe_n));
`default_nettype wire

// *** bench/ssu_core_tb.sv ***
// Self-checking bench for the serial control core.
`timescale 1ns/100ps
`default_nettype none
`include "ssu_defs.vh"
module ssu_core_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h00000000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        codecRun = 1'b0;
  logic [15:0] lfsrQ = 16'he7e1;
  logic [31:0] rdv;
  wire  logic [31:0] regRdata;
  wire  logic irq, txData, txFrame, txClkOut, rxClkOut, rxClkOe_n, rxData, rxFrame, rxClk;
  int error_cnt = 0;
  int checks = 0;
  // Master clock, 8 ns period.
  always #4 clk = ~clk;
  ssu_core dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .txData(txData),
    .txFrame(txFrame), .txClkOut(txClkOut), .rxDataIn(rxData), .rxFrameIn(rxFrame),
    .rxClkIn(rxClk), .rxClkOut(rxClkOut), .rxClkOe_n(rxClkOe_n));
  ssu_codec_model codec_u (.clk(clk), .run(codecRun), .bitClk(rxClk), .dataOut(rxData),
    .frameOut(rxFrame));
  function logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Only the low twelve divider bits are kept.
  function logic [31:0] exp_div(input logic [31:0] d);
    return {20'h00000, d[11:0]};
  endfunction
  task close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); regAddr <= a; regWdata <= d; regWr <= 1'b1;
    @(posedge clk); regWr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk); regAddr <= a; regRd <= 1'b1;
    @(posedge clk); regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rdv);
    chk(rdv, e);
  endtask
  // Write then read with no gap between the strobes.
  task wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [7:0] ra);
    @(posedge clk); regAddr <= a; regWdata <= d; regWr <= 1'b1;
    @(posedge clk); regWr <= 1'b0; regAddr <= ra; regRd <= 1'b1;
    @(posedge clk); regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task count_tog(input logic sel, input int n, output int c);
    logic last;
    c = 0;
    @(posedge clk); #1 last = sel ? rxClkOut : txClkOut;
    repeat (n) begin
      @(posedge clk); #1 if ((sel ? rxClkOut : txClkOut) !== last) c++;
      last = sel ? rxClkOut : txClkOut;
    end
  endtask
  task wait_st(input int b, input logic v);
    for (int i = 0; i < 300; i++) begin
      rd(`SSU_OFF_STATUS, rdv);
      if (rdv[b] === v) break;
    end
    chk({31'h0, rdv[b]}, {31'h0, v});
    if (rdv[b] !== v) close_out();
  endtask
  // Main sequence: registers, divider, clock routing, then traffic and interrupts.
  initial begin
    int n, c;
    logic [31:0] d;
    logic [7:0] offs [8];
    offs = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h34, 8'h38, 8'h3c};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`SSU_OFF_STATUS, `SSU_STATUS_RST);
    rd_chk(`SSU_OFF_IMASK, 32'h00000000);
    for (int k = 0; k < 8; k++) begin
      lfsrQ = lfsr_next(lfsrQ);
      d = {lfsrQ, lfsr_next(lfsrQ)};
      wr(offs[k], d);
      rd_chk(offs[k], offs[k] == `SSU_OFF_CLKDIV ? exp_div(d) : d);
    end
    wr(8'h08, 32'hffffffff);
    rd_chk(8'h08, 32'h00000000);
    rd_chk(`SSU_OFF_TXHOLD, 32'h00000000);
    wr(`SSU_OFF_CTRL, 32'h00008101);
    for (int k = 0; k < 8; k++) rd_chk(offs[k], 32'h00000000);
    rd_chk(`SSU_OFF_STATUS, `SSU_STATUS_RST);
    wr(`SSU_OFF_CTRL, 32'h00000303);
    rd(`SSU_OFF_STATUS, rdv);
    chk(rdv & 32'h00030000, 32'h00000000);
    for (int k = 0; k < 9; k++) begin
      d = (k << 8) | ((k % 3) << 6);
      wr(`SSU_OFF_RXCLK, d);
      rd_chk(`SSU_OFF_RXCLK, d);
    end
    for (int k = 0; k < 5; k++) begin
      lfsrQ = lfsr_next(lfsrQ);
      n = (k == 0) ? 0 : ((k == 4) ? 4095 : lfsrQ[3:0] + 1);
      wr(`SSU_OFF_CLKDIV, {lfsrQ, lfsrQ[15:12], n[11:0]});
      repeat (2 * n + 4) @(posedge clk);
      count_tog(1'b0, (n == 0) ? 64 : 4 * n, c);
      chk(c, (n == 0) ? 32'h0 : 32'h4);
    end
    wr(`SSU_OFF_CLKDIV, 32'h00000004);
    for (int s = 0; s < 3; s++) begin
      wr(`SSU_OFF_RXCLK, 32'h00000004 | s);
      codecRun <= (s == 2);
      repeat (40) @(posedge clk);
      count_tog(1'b1, 80, c);
      chk(c, (s == 2) ? 32'h0a : 32'h14);
    end
    codecRun <= 1'b0;
    repeat (20) @(posedge clk);
    count_tog(1'b1, 80, c);
    chk(c, 32'h0);
    wr(`SSU_OFF_RXFRM, 32'h00000027);
    repeat (20) @(posedge clk);
    count_tog(1'b1, 80, c);
    chk(c, 32'h14);
    wr(`SSU_OFF_RXCLK, 32'h00000002);
    wr(`SSU_OFF_TXFRM, 32'h00000007);
    wr_rd(`SSU_OFF_IEN_SET, 32'h00000010, `SSU_OFF_IMASK);
    chk(rdv, 32'h00000010);
    wr(`SSU_OFF_CTRL, 32'h00000101);
    wr(`SSU_OFF_TXHOLD, {lfsrQ, lfsrQ});
    wr(`SSU_OFF_TXHOLD, {lfsrQ, ~lfsrQ});
    for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    if (irq !== 1'b1) close_out();
    repeat (20) @(posedge clk);
    wr(`SSU_OFF_CTRL, 32'h00000002);
    rd(`SSU_OFF_STATUS, rdv);
    chk({31'h0, rdv[`SSU_ST_RX_ENABLE_CMD]}, 32'h1);
    wait_st(`SSU_ST_RX_ENABLE_CMD, 1'b0);
    wait_st(`SSU_ST_TXEMPTY, 1'b1);
    wr(`SSU_OFF_TXHOLD, {lfsrQ, lfsrQ});
    wr(`SSU_OFF_TXHOLD, ~{lfsrQ, lfsrQ});
    repeat (40) @(posedge clk);
    rd(`SSU_OFF_STATUS, rdv);
    chk({31'h0, rdv[`SSU_ST_TXEMPTY]}, 32'h0);
    wr(`SSU_OFF_CTRL, 32'h00000200);
    rd(`SSU_OFF_STATUS, rdv);
    chk({31'h0, rdv[`SSU_ST_TX_ENABLE_CMD]}, 32'h1);
    wait_st(`SSU_ST_TX_ENABLE_CMD, 1'b0);
    wr_rd(`SSU_OFF_IEN_CLR, 32'hffffffff, `SSU_OFF_IMASK);
    chk(rdv, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
    wr(`SSU_OFF_SCLR, 32'h00000010);
    wr(`SSU_OFF_IEN_SET, 32'h00000010);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    close_out();
  end
endmodule // ssu_core_tb
`default_nettype wire

// *** rtl/ssu_core.v ***
// Control, clock divider, bit shifters, interrupt and register logic of the serial unit.
`timescale 1ns/100ps
`default_nettype none
`include "ssu_defs.vh"

// What this block does
// - Loop bit routes transmit data, frame sync and clock into the receiver.
// - Enable-set writes set mask bits, enable-clear writes clear them; mask readable.
// - Interrupt output high while any status event has its mask bit set.
// - Control bit 0 enables receiver unless bit 1 written together.
// - Receive disable waits for the character in progress to finish.
// - Control bit 8 enables transmitter unless bit 9 written together.
// - Transmit disable waits for the character in progress to finish.
// - Control bit 15 soft reset overrides all other bits of that write.
// - Divider value zero stops the divided clock.
// - Nonzero divider N gives master clock over two times N.
// - Divider field is twelve bits, down to master clock over 8190.
// - Receive clock source: divided, transmit clock, receive clock pin.
// - Receive clock pin: input, driven always, or only during transfers.
// - Continuous transmit start never sends frame sync data.
// - Continuous start, zero delay: held words shift out back to back; a write while full replaces the held word.
// - Receive start codes select continuous, with transmitter, or any frame sync change.
// - Receive clock gating: continuous, while frame sync low, while high.
module ssu_core (
  input  wire        clk,        // Master clock, 125 MHz.
  input  wire        rst,        // Synchronous reset, active high.
  input  wire [7:0]  regAddr,    // Register byte address.
  input  wire [31:0] regWdata,   // Write data.
  input  wire        regWr,      // Write strobe.
  input  wire        regRd,      // Read strobe.
  output reg  [31:0] regRdata,   // Read data, valid the cycle after the read strobe.
  output reg         irq,        // Level interrupt.
  output reg         txData,     // Transmit data line.
  output reg         txFrame,    // Transmit frame sync output.
  output reg         txClkOut,   // Transmit clock output.
  input  wire        rxDataIn,   // Receive data pin.
  input  wire        rxFrameIn,  // Receive frame sync pin.
  input  wire        rxClkIn,    // Receive clock pin input.
  output reg         rxClkOut,   // Receive clock pin output value.
  output reg         rxClkOe_n   // Receive clock pin enable, low while driven.
);

  // Pin inputs pass two flip-flops before any logic reads them.
  // Only the second stage is read anywhere, so a metastable first stage
  // never reaches a decision. The cost is two master cycles of latency on
  // every pin, which bounds the highest usable external bit clock.
  reg [1:0] rxDataS_q;
  reg [1:0] rxFrameS_q;
  reg [1:0] rxClkS_q;
  always @(posedge clk) begin
    rxDataS_q  <= {rxDataS_q[0], rxDataIn};
    rxFrameS_q <= {rxFrameS_q[0], rxFrameIn};
    rxClkS_q   <= {rxClkS_q[0], rxClkIn};
  end

  // Configuration, holding and status storage, one register per line.
  reg [31:0] clkDiv_q;
  reg [31:0] rxClkMode_q;
  reg [31:0] rxFrmMode_q;
  reg [31:0] txClkMode_q;
  reg [31:0] txFrmMode_q;
  reg [31:0] txSync_q;
  reg [31:0] cmp0_q;
  reg [31:0] cmp1_q;
  reg [31:0] rxHold_q;
  reg [31:0] rxSync_q;
  reg [31:0] txHold_q;
  reg [31:0] mask_q;
  reg [31:0] status_q;
  reg        rx_enable_cmd_q;
  reg        tx_enable_cmd_q;
  reg        rxDisPend_q;
  reg        txDisPend_q;
  reg        txHoldFull_q;

  // Write decodes shared by several processes.
  // The soft reset is folded into one reset term so that every register but the read
  // data returns to its reset value in the same cycle as a pin reset would.
  wire wrCtrl  = regWr && (regAddr == `SSU_OFF_CTRL);
  wire softRst = wrCtrl && regWdata[`SSU_BIT_SRST];
  wire anyRst  = rst || softRst;
  wire wrTxHold = regWr && (regAddr == `SSU_OFF_TXHOLD);

  // Divided clock: toggles every N master cycles, so the period is 2N.
  // A new divider value takes effect at once; the compare is a greater or
  // equal so a counter above a smaller new value wraps instead of running
  // through the whole twelve-bit range first.
  reg [`SSU_DIV_W-1:0] divCnt_q;
  reg                  divClk_q;
  wire [`SSU_DIV_W-1:0] divN = clkDiv_q[`SSU_DIV_W-1:0];
  always @(posedge clk) begin
    if (anyRst || divN == {`SSU_DIV_W{1'b0}}) begin
      divCnt_q <= {`SSU_DIV_W{1'b0}};
      divClk_q <= 1'b0;
    end else if (divCnt_q >= divN - 1'b1) begin
      divCnt_q <= {`SSU_DIV_W{1'b0}};
      divClk_q <= ~divClk_q;
    end else begin
      divCnt_q <= divCnt_q + 1'b1;
    end
  end

  // Transmit bit clock is the divided clock here; its mode fields live elsewhere.
  // Shifters advance on the rising edge of the bit clock, seen as a one-cycle
  // tick, so all logic stays on the master clock with no second domain.
  wire txBitClk = divClk_q;
  reg  txBitClkD_q;
  always @(posedge clk) begin
    txBitClkD_q <= txBitClk;
  end
  wire txTick = txBitClk && !txBitClkD_q;

  // Receive side selection, loop routing and gating.
  // Loop mode overrides the source field, so software can test the data
  // path without touching the receive clock setting it will later need.
  // The reserved source code yields a still clock rather than a guess.
  wire [1:0] rxCks  = rxClkMode_q[`SSU_CKS_LSB+1:`SSU_CKS_LSB];
  wire [2:0] rxCko  = rxClkMode_q[`SSU_CKO_LSB+2:`SSU_CKO_LSB];
  wire [1:0] rxCkg  = rxClkMode_q[`SSU_CKG_LSB+1:`SSU_CKG_LSB];
  wire [3:0] rxStrt = rxClkMode_q[`SSU_START_LSB+`SSU_START_W-1:`SSU_START_LSB];
  wire       loopOn = rxFrmMode_q[`SSU_LOOP_BIT];
  wire rxDataSel  = loopOn ? txData  : rxDataS_q[1];
  wire rxFrameSel = loopOn ? txFrame : rxFrameS_q[1];
  reg  rxSrcClk;
  always @* begin
    if (loopOn)                     rxSrcClk = txBitClk;
    else if (rxCks == `SSU_CKS_DIV) rxSrcClk = divClk_q;
    else if (rxCks == `SSU_CKS_TX)  rxSrcClk = txBitClk;
    else if (rxCks == `SSU_CKS_PIN) rxSrcClk = rxClkS_q[1];
    else                            rxSrcClk = 1'b0;
  end
  reg rxGateOk;
  always @* begin
    case (rxCkg)
      `SSU_CKG_LOW:  rxGateOk = !rxFrameSel;
      `SSU_CKG_HIGH: rxGateOk = rxFrameSel;
      default:       rxGateOk = 1'b1;
    endcase
  end
  // Edge of the selected receive clock; gating masks the tick, not the clock,
  // so the edge history stays true while the gate is closed.
  reg rxSrcD_q;
  always @(posedge clk) begin
    rxSrcD_q <= rxSrcClk;
  end
  wire rxTick = rxSrcClk && !rxSrcD_q && rxGateOk;

  // Receive start: continuous, with transmitter, otherwise any frame sync edge.
  // Level, edge and compare starts are all reduced to any change of frame
  // sync; a user needing the finer codes must filter in software.
  reg rxFrmD_q;
  always @(posedge clk) begin
    rxFrmD_q <= rxFrameSel;
  end
  reg txBusy_q;
  reg rxStartOk;
  always @* begin
    if (rxStrt == `SSU_START_CONT) rxStartOk = 1'b1;
    else if (rxStrt == 4'h1)       rxStartOk = txBusy_q;
    else                           rxStartOk = rxFrameSel ^ rxFrmD_q;
  end

  // Receiver shifter; DATLEN+1 bits per character, MSB first.
  // The first sampled bit arrives with the start tick itself, so the count
  // begins at one and the character ends when the count meets the length.
  // A finished character overwrites the holding register even if unread.
  reg [31:0] rxShift_q;
  reg [4:0]  rxCnt_q;
  reg        rxBusy_q;
  wire [4:0] rxLen = rxFrmMode_q[`SSU_DATLEN_W-1:0];
  wire rxDone = rxBusy_q && rxTick && (rxCnt_q == rxLen);
  always @(posedge clk) begin
    if (anyRst) begin
      rxShift_q <= `SSU_ZERO32;
      rxCnt_q   <= 5'h00;
      rxBusy_q  <= 1'b0;
      rxHold_q  <= `SSU_ZERO32;
    end else if (rxTick && rx_enable_cmd_q) begin
      rxShift_q <= {rxShift_q[30:0], rxDataSel};
      if (!rxBusy_q && rxStartOk) begin
        rxBusy_q <= 1'b1;
        rxCnt_q  <= 5'h01;
      end else if (rxDone) begin
        rxBusy_q <= 1'b0;
        rxHold_q <= {rxShift_q[30:0], rxDataSel};
      end else if (rxBusy_q) begin
        rxCnt_q <= rxCnt_q + 5'h01;
      end
    end
  end

  // Transmitter shifter; continuous start loads the next word as soon as one is held.
  // Loading on the tick that ends a character keeps words back to back with
  // no idle bit between them, which is what continuous mode promises.
  reg [31:0] txShift_q;
  reg [4:0]  txCnt_q;
  wire [4:0] txLen = txFrmMode_q[`SSU_DATLEN_W-1:0];
  wire txDone = txBusy_q && txTick && (txCnt_q == txLen);
  wire txLoad = txTick && tx_enable_cmd_q && txHoldFull_q && (!txBusy_q || txDone);
  always @(posedge clk) begin
    if (anyRst) begin
      txShift_q <= `SSU_ZERO32;
      txCnt_q   <= 5'h00;
      txBusy_q  <= 1'b0;
      txData    <= 1'b0;
    end else if (txLoad) begin
      txShift_q <= {txHold_q[30:0], 1'b0};
      txData    <= txHold_q[txLen];
      txCnt_q   <= 5'h01;
      txBusy_q  <= 1'b1;
    end else if (txTick && txBusy_q) begin
      txData    <= txShift_q[txLen];
      txShift_q <= {txShift_q[30:0], 1'b0};
      txCnt_q   <= txCnt_q + 5'h01;
      if (txDone) txBusy_q <= 1'b0;
    end
  end

  // Frame sync data is suppressed: only continuous start is built, so sync never shows.
  always @(posedge clk) begin
    if (anyRst) txFrame <= 1'b0;
    else        txFrame <= 1'b0;
  end

  // Holding register; write while full overwrites, trading loss for no stall.
  // Software should wait for the ready flag before writing again.
  always @(posedge clk) begin
    if (anyRst) begin
      txHold_q     <= `SSU_ZERO32;
      txHoldFull_q <= 1'b0;
    end else if (wrTxHold) begin
      txHold_q     <= regWdata;
      txHoldFull_q <= 1'b1;
    end else if (txLoad) begin
      txHoldFull_q <= 1'b0;
    end
  end

  // Enable and disable commands; a disable during a character waits for its end.
  // Disable is tested first, so a write that holds both bits disables.
  // Between characters the disable takes effect at once.
  always @(posedge clk) begin
    if (anyRst) begin
      rx_enable_cmd_q      <= 1'b0;
      tx_enable_cmd_q      <= 1'b0;
      rxDisPend_q <= 1'b0;
      txDisPend_q <= 1'b0;
    end else begin
      if (wrCtrl && regWdata[`SSU_BIT_RX_DISABLE_CMD]) begin
        if (rxBusy_q && !rxDone) rxDisPend_q <= 1'b1;
        else rx_enable_cmd_q <= 1'b0;
      end else if (wrCtrl && regWdata[`SSU_BIT_RX_ENABLE_CMD]) begin
        rx_enable_cmd_q <= 1'b1;
        rxDisPend_q <= 1'b0;
      end else if (rxDisPend_q && (rxDone || !rxBusy_q)) begin
        rx_enable_cmd_q <= 1'b0;
        rxDisPend_q <= 1'b0;
      end
      if (wrCtrl && regWdata[`SSU_BIT_TX_DISABLE_CMD]) begin
        if (txBusy_q && !txDone) txDisPend_q <= 1'b1;
        else tx_enable_cmd_q <= 1'b0;
      end else if (wrCtrl && regWdata[`SSU_BIT_TX_ENABLE_CMD]) begin
        tx_enable_cmd_q <= 1'b1;
        txDisPend_q <= 1'b0;
      end else if (txDisPend_q && (txDone || !txBusy_q)) begin
        tx_enable_cmd_q <= 1'b0;
        txDisPend_q <= 1'b0;
      end
    end
  end

  // Receive and transmit clock pins.
  // The pin copies lag the internal clock by one cycle; this is harmless since
  // the far side only needs a steady period, not a fixed phase.
  always @(posedge clk) begin
    if (anyRst) begin
      rxClkOut  <= 1'b0;
      rxClkOe_n <= 1'b1;
      txClkOut  <= 1'b0;
    end else begin
      txClkOut <= txBitClk;
      rxClkOut <= rxSrcClk;
      if (rxCko == `SSU_CKO_CONT)      rxClkOe_n <= 1'b0;
      else if (rxCko == `SSU_CKO_XFER) rxClkOe_n <= !rxBusy_q;
      else                             rxClkOe_n <= 1'b1;
    end
  end

  // Sticky events: set wins over a same-cycle clear.
  // The empty flag reads as one only while the transmitter is enabled, so the
  // status word holds its reset value until software enables a direction.
  wire [31:0] evSet = ({31'h0, txLoad} << `SSU_ST_TXRDY)
                    | ({31'h0, rxDone} << `SSU_ST_RXRDY)
                    | ({31'h0, rxDone && status_q[`SSU_ST_RXRDY]} << `SSU_ST_OVRUN);
  wire rdRxHold = regRd && (regAddr == `SSU_OFF_RXHOLD);
  wire [31:0] evClr = (regWr && regAddr == `SSU_OFF_SCLR) ? regWdata : `SSU_ZERO32;
  wire [31:0] rdClr = rdRxHold ? ({31'h0, 1'b1} << `SSU_ST_RXRDY) : `SSU_ZERO32;
  always @(posedge clk) begin
    if (anyRst) begin
      status_q <= `SSU_STATUS_RST;
    end else begin
      status_q <= ((status_q & ~evClr & ~rdClr) | evSet);
      status_q[`SSU_ST_TXEMPTY] <= tx_enable_cmd_q && !txBusy_q && !txHoldFull_q;
      status_q[`SSU_ST_TX_ENABLE_CMD]    <= tx_enable_cmd_q;
      status_q[`SSU_ST_RX_ENABLE_CMD]    <= rx_enable_cmd_q;
    end
  end

  // Mask set and clear; interrupt from masked status.
  // The interrupt is registered, so it follows the status by one cycle.
  always @(posedge clk) begin
    if (anyRst) begin
      mask_q <= `SSU_ZERO32;
      irq    <= 1'b0;
    end else begin
      if (regWr && regAddr == `SSU_OFF_IEN_SET)      mask_q <= mask_q | regWdata;
      else if (regWr && regAddr == `SSU_OFF_IEN_CLR) mask_q <= mask_q & ~regWdata;
      irq <= |(status_q & mask_q);
    end
  end

  // Configuration writes.
  always @(posedge clk) begin
    if (anyRst) begin
      clkDiv_q    <= `SSU_ZERO32;
      rxClkMode_q <= `SSU_ZERO32;
      rxFrmMode_q <= `SSU_ZERO32;
      txClkMode_q <= `SSU_ZERO32;
      txFrmMode_q <= `SSU_ZERO32;
      txSync_q    <= `SSU_ZERO32;
      cmp0_q      <= `SSU_ZERO32;
      cmp1_q      <= `SSU_ZERO32;
      rxSync_q    <= `SSU_ZERO32;
    end else if (regWr) begin
      if (regAddr == `SSU_OFF_CLKDIV)      clkDiv_q <= {20'h0, regWdata[`SSU_DIV_W-1:0]};
      else if (regAddr == `SSU_OFF_RXCLK)  rxClkMode_q <= regWdata;
      else if (regAddr == `SSU_OFF_RXFRM)  rxFrmMode_q <= regWdata;
      else if (regAddr == `SSU_OFF_TXCLK)  txClkMode_q <= regWdata;
      else if (regAddr == `SSU_OFF_TXFRM)  txFrmMode_q <= regWdata;
      else if (regAddr == `SSU_OFF_TXSYNC) txSync_q <= regWdata;
      else if (regAddr == `SSU_OFF_CMP0)   cmp0_q <= regWdata;
      else if (regAddr == `SSU_OFF_CMP1)   cmp1_q <= regWdata;
    end
  end

  // Read mux; unmapped and write-only addresses read zero.
  // Data stand for one cycle only and fall back to zero, so a stale word can
  // never be mistaken for the answer to a later read.
  always @(posedge clk) begin
    if (rst) regRdata <= `SSU_ZERO32;
    else if (!regRd) regRdata <= `SSU_ZERO32;
    else if (regAddr == `SSU_OFF_CLKDIV) regRdata <= clkDiv_q;
    else if (regAddr == `SSU_OFF_RXCLK)  regRdata <= rxClkMode_q;
    else if (regAddr == `SSU_OFF_RXFRM)  regRdata <= rxFrmMode_q;
    else if (regAddr == `SSU_OFF_TXCLK)  regRdata <= txClkMode_q;
    else if (regAddr == `SSU_OFF_TXFRM)  regRdata <= txFrmMode_q;
    else if (regAddr == `SSU_OFF_RXHOLD) regRdata <= rxHold_q;
    else if (regAddr == `SSU_OFF_RXSYNC) regRdata <= rxSync_q;
    else if (regAddr == `SSU_OFF_TXSYNC) regRdata <= txSync_q;
    else if (regAddr == `SSU_OFF_CMP0)   regRdata <= cmp0_q;
    else if (regAddr == `SSU_OFF_CMP1)   regRdata <= cmp1_q;
    else if (regAddr == `SSU_OFF_STATUS) regRdata <= status_q;
    else if (regAddr == `SSU_OFF_IMASK)  regRdata <= mask_q;
    else regRdata <= `SSU_ZERO32;
  end

endmodule // ssu_core
`default_nettype wire

// *** rtl/ssu_defs.vh ***
// Register offsets, field positions and reset values of the serial control core.
`ifndef SSU_DEFS_VH
`define SSU_DEFS_VH
`define SSU_OFF_CTRL     8'h00
`define SSU_OFF_CLKDIV   8'h04
`define SSU_OFF_RXCLK    8'h10
`define SSU_OFF_RXFRM    8'h14
`define SSU_OFF_TXCLK    8'h18
`define SSU_OFF_TXFRM    8'h1c
`define SSU_OFF_RXHOLD   8'h20
`define SSU_OFF_TXHOLD   8'h24
`define SSU_OFF_RXSYNC   8'h30
`define SSU_OFF_TXSYNC   8'h34
`define SSU_OFF_CMP0     8'h38
`define SSU_OFF_CMP1     8'h3c
`define SSU_OFF_STATUS   8'h40
`define SSU_OFF_IEN_SET  8'h44
`define SSU_OFF_IEN_CLR  8'h48
`define SSU_OFF_IMASK    8'h4c
`define SSU_OFF_SCLR     8'h50
`define SSU_BIT_RX_ENABLE_CMD     0
`define SSU_BIT_RX_DISABLE_CMD    1
`define SSU_BIT_TX_ENABLE_CMD     8
`define SSU_BIT_TX_DISABLE_CMD    9
`define SSU_BIT_SRST     15
`define SSU_DIV_W        12
`define SSU_LOOP_BIT     5
`define SSU_SYNC_DATA_SEND_ENABLE_BIT    23
`define SSU_START_LSB    8
`define SSU_START_W      4
`define SSU_START_DELAY_BITS_LSB   16
`define SSU_CKS_LSB      0
`define SSU_CKO_LSB      2
`define SSU_CKG_LSB      6
`define SSU_DATLEN_W     5
`define SSU_CKS_DIV      2'h0
`define SSU_CKS_TX       2'h1
`define SSU_CKS_PIN      2'h2
`define SSU_CKO_NONE     3'h0
`define SSU_CKO_CONT     3'h1
`define SSU_CKO_XFER     3'h2
`define SSU_CKG_NONE     2'h0
`define SSU_CKG_LOW      2'h1
`define SSU_CKG_HIGH     2'h2
`define SSU_START_CONT   4'h0
`define SSU_ST_TXRDY     0
`define SSU_ST_TXEMPTY   1
`define SSU_ST_RXRDY     4
`define SSU_ST_OVRUN     5
`define SSU_ST_TX_ENABLE_CMD      16
`define SSU_ST_RX_ENABLE_CMD      17
`define SSU_STATUS_RST   32'h000000cc
`define SSU_ZERO32       32'h00000000
`endif
